// file: fsh_pkg.sv
// Shared constants, types and timing for the flash status-polling host controller.
package fsh_pkg;

  // ==========================================================================
  // Widths and status byte layout
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int WINDOW_BIT = 3;
  localparam int SECTOR_TOGGLE_BIT = 2;

  // ==========================================================================
  // Command codes and sequence lengths
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [2:0] PROG_SEQ_LEN = 3'h4;
  localparam logic [2:0] ERASE_SEQ_LEN = 3'h6;
  localparam logic [2:0] SINGLE_SEQ_LEN = 3'h1;

  // ==========================================================================
  // Timing
  localparam int CLK_NS = 50;
  localparam int T_WP_NS = 100;
  localparam int T_ACC_NS = 120;
  localparam int T_GAP_NS = 50;
  localparam int T_WINDOW_US = 80;
  localparam int T_SUSPEND_US = 20;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [3:0] WP_CYC = 4'(cyc_up(T_WP_NS));
  localparam logic [3:0] ACC_CYC = 4'(cyc_up(T_ACC_NS));
  localparam logic [3:0] SYNC_CYC = 4'h3;
  localparam logic [3:0] GAP_CYC = 4'(cyc_up(T_GAP_NS));
  localparam logic [10:0] WINDOW_CYC = 11'(cyc_dn(T_WINDOW_US * 1000));
  localparam logic [9:0] SUSPEND_CYC = 10'(cyc_up(T_SUSPEND_US * 1000));

  // ==========================================================================
  // User operations and state machines
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_PROGRAM = 4'h1, OP_CHIP_ERASE = 4'h2, OP_SECTOR_ERASE = 4'h3,
    OP_ADD_SECTOR = 4'h4, OP_WAIT = 4'h5, OP_SUSPEND = 4'h6, OP_RESUME = 4'h7,
    OP_RESET = 4'h8
  } fsh_op_t;

  typedef enum logic [2:0] {
    CY_IDLE = 3'b000, CY_WSET = 3'b001, CY_WLOW = 3'b010, CY_WHOLD = 3'b011,
    CY_RWAIT = 3'b100, CY_GAP = 3'b101
  } fsh_cyc_state_t;

  typedef enum logic [3:0] {
    HS_INIT = 4'b0000, HS_IDLE = 4'b0001, HS_SEQ = 4'b0010, HS_PRE = 4'b0011,
    HS_POLL = 4'b0100, HS_FINAL = 4'b0101, HS_POST = 4'b0110, HS_RESET = 4'b0111,
    HS_RESP = 4'b1000
  } fsh_host_state_t;

endpackage

// file: fsh_cyc_if.sv
// Bus-cycle request channel between the host sequencer and the pin engine.
interface fsh_cyc_if;
  import fsh_pkg::*;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic ack;
  logic [DATA_W-1:0] rdata;
  modport master(output req, output wr, output addr, output wdata, input ack, input rdata);
  modport engine(input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface

// file: fsh_cycle.sv
// Pin engine that runs one strobed read or write cycle on the flash bus.
module fsh_cycle (
  input logic sys_clk,
  input logic rstn,
  input logic clk_en,
  fsh_cyc_if.engine cyc,
  output logic [fsh_pkg::ADDR_W-1:0] fl_addr,
  output logic [fsh_pkg::DATA_W-1:0] fl_dq_out,
  output logic fl_dq_oe,
  input logic [fsh_pkg::DATA_W-1:0] fl_dq_in,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n
);
  import fsh_pkg::*;

  fsh_cyc_state_t st;
  logic [3:0] cnt;
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic [DATA_W-1:0] dq_s3;
  logic ack;
  logic [DATA_W-1:0] rdata;

  assign cyc.ack = ack;
  assign cyc.rdata = rdata;

  // ==========================================================================
  // Data pin synchroniser
  // The flash may change its status bits while output enable is low, so a
  // byte is only taken once the last two stages agree.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      dq_s3 <= 8'h00;
    end else if (clk_en) begin
      dq_s1 <= fl_dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // ==========================================================================
  // Cycle sequencer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= CY_IDLE;
      cnt <= 4'h0;
      ack <= 1'b0;
      rdata <= 8'h00;
      fl_addr <= '0;
      fl_dq_out <= 8'h00;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
    end else if (clk_en) begin
      ack <= 1'b0;
      case (st)
        CY_IDLE: begin
          cnt <= 4'h0;
          if (cyc.req) begin
            fl_addr <= cyc.addr;
            fl_ce_n <= 1'b0;
            if (cyc.wr) begin
              fl_dq_out <= cyc.wdata;
              fl_dq_oe <= 1'b1;
              st <= CY_WSET;
            end else begin
              fl_oe_n <= 1'b0;
              st <= CY_RWAIT;
            end
          end
        end
        CY_WSET: begin
          fl_we_n <= 1'b0;
          st <= CY_WLOW;
        end
        CY_WLOW: begin
          if (cnt == WP_CYC - 4'h1) begin
            fl_we_n <= 1'b1;
            st <= CY_WHOLD;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        CY_WHOLD: begin
          fl_ce_n <= 1'b1;
          fl_dq_oe <= 1'b0;
          ack <= 1'b1;
          cnt <= 4'h0;
          st <= CY_GAP;
        end
        CY_RWAIT: begin
          if (cnt >= ACC_CYC + SYNC_CYC && dq_s2 == dq_s3) begin
            rdata <= dq_s3;
            fl_oe_n <= 1'b1;
            fl_ce_n <= 1'b1;
            ack <= 1'b1;
            cnt <= 4'h0;
            st <= CY_GAP;
          end else if (cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
          end
        end
        CY_GAP: begin
          if (cnt >= GAP_CYC - 4'h1) begin
            st <= CY_IDLE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        default: st <= CY_IDLE;
      endcase
    end
  end

endmodule

// file: fsh_host.sv
// Host controller that issues flash commands and decodes the embedded status byte.
module fsh_host #(
  parameter logic [fsh_pkg::ADDR_W-1:0] UNLOCK_ADDR1 = 20'h00001,
  parameter logic [fsh_pkg::ADDR_W-1:0] UNLOCK_ADDR2 = 20'h00002,
  parameter logic [7:0] UNLOCK_DATA1 = 8'h01,
  parameter logic [7:0] UNLOCK_DATA2 = 8'h02,
  parameter logic [7:0] CMD_PROGRAM = 8'h03,
  parameter logic [7:0] CMD_ERASE_SETUP = 8'h04,
  parameter logic [7:0] CMD_CHIP_ERASE = 8'h05,
  parameter logic [7:0] CMD_SUSPEND = 8'h06,
  parameter logic [7:0] CMD_RESET = 8'h07
) (
  input logic sys_clk,
  input logic rstn,
  input logic clk_en,
  input logic cmd_valid,
  input fsh_pkg::fsh_op_t cmd_op,
  input logic [fsh_pkg::ADDR_W-1:0] cmd_addr,
  input logic [fsh_pkg::DATA_W-1:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [fsh_pkg::DATA_W-1:0] rsp_data,
  output logic [fsh_pkg::DATA_W-1:0] rsp_status,
  output logic rsp_fail,
  output logic rsp_reject,
  output logic rsp_mismatch,
  output logic erase_active,
  output logic erase_suspended,
  output logic [fsh_pkg::ADDR_W-1:0] fl_addr,
  output logic [fsh_pkg::DATA_W-1:0] fl_dq_out,
  output logic fl_dq_oe,
  input logic [fsh_pkg::DATA_W-1:0] fl_dq_in,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n
);
  import fsh_pkg::*;

  fsh_cyc_if cyc();
  fsh_host_state_t st;
  fsh_op_t op;
  logic [ADDR_W-1:0] op_addr;
  logic [DATA_W-1:0] op_data;
  logic [2:0] step;
  logic [DATA_W-1:0] prev;
  logic have_prev;
  logic [1:0] to_cnt;
  logic chip_mode;
  logic booted;
  logic win_restart;
  logic [10:0] win_cnt;
  logic [9:0] susp_cnt;
  logic req;
  logic req_wr;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_data;
  logic [DATA_W-1:0] rd;
  logic toggle_same;

  assign cyc.req = req;
  assign cyc.wr = req_wr;
  assign cyc.addr = req_addr;
  assign cyc.wdata = req_data;
  assign rd = cyc.rdata;
  assign toggle_same = have_prev && (rd[TOGGLE_BIT] == prev[TOGGLE_BIT]);

  fsh_cycle u_cycle (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .cyc(cyc.engine),
    .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_in(fl_dq_in),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n)
  );

  // ==========================================================================
  // Command sequences
  function automatic logic [ADDR_W+7:0] seq_word(input fsh_op_t o, input logic [2:0] i,
                                                 input logic [ADDR_W-1:0] a,
                                                 input logic [7:0] d);
    case (o)
      OP_PROGRAM: begin
        case (i)
          3'h0: return {UNLOCK_ADDR1, UNLOCK_DATA1};
          3'h1: return {UNLOCK_ADDR2, UNLOCK_DATA2};
          3'h2: return {UNLOCK_ADDR1, CMD_PROGRAM};
          default: return {a, d};
        endcase
      end
      OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
        case (i)
          3'h0, 3'h3: return {UNLOCK_ADDR1, UNLOCK_DATA1};
          3'h1, 3'h4: return {UNLOCK_ADDR2, UNLOCK_DATA2};
          3'h2: return {UNLOCK_ADDR1, CMD_ERASE_SETUP};
          default: return (o == OP_CHIP_ERASE) ? {UNLOCK_ADDR1, CMD_CHIP_ERASE}
                                                : {a, CMD_SECTOR_ERASE};
        endcase
      end
      OP_ADD_SECTOR: return {a, CMD_SECTOR_ERASE};
      OP_SUSPEND: return {a, CMD_SUSPEND};
      OP_RESUME: return {a, CMD_RESUME};
      default: return {a, CMD_RESET};
    endcase
  endfunction

  function automatic logic seq_last(input fsh_op_t o, input logic [2:0] i);
    case (o)
      OP_PROGRAM: return i == PROG_SEQ_LEN - 3'h1;
      OP_CHIP_ERASE, OP_SECTOR_ERASE: return i == ERASE_SEQ_LEN - 3'h1;
      default: return i == SINGLE_SEQ_LEN - 3'h1;
    endcase
  endfunction

  // ==========================================================================
  // Erase window and suspend timers
  // The window is tracked locally so that a late added sector is refused
  // before it can cancel the pending erase.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      win_cnt <= 11'h000;
      susp_cnt <= 10'h000;
    end else if (clk_en) begin
      if (win_restart) begin
        win_cnt <= WINDOW_CYC;
      end else if (win_cnt != 11'h000) begin
        win_cnt <= win_cnt - 11'h001;
      end
      if (st == HS_POLL && op == OP_SUSPEND) begin
        if (susp_cnt != SUSPEND_CYC) begin
          susp_cnt <= susp_cnt + 10'h001;
        end
      end else begin
        susp_cnt <= 10'h000;
      end
    end
  end

  // ==========================================================================
  // Command sequencer
  task automatic issue(input logic w, input logic [ADDR_W+7:0] ad);
    req <= 1'b1;
    req_wr <= w;
    req_addr <= ad[ADDR_W+7:8];
    req_data <= ad[7:0];
  endtask

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= HS_INIT;
      op <= OP_READ;
      op_addr <= '0;
      op_data <= 8'h00;
      step <= 3'h0;
      prev <= 8'h00;
      have_prev <= 1'b0;
      to_cnt <= 2'h0;
      chip_mode <= 1'b0;
      booted <= 1'b0;
      win_restart <= 1'b0;
      req <= 1'b0;
      req_wr <= 1'b0;
      req_addr <= '0;
      req_data <= 8'h00;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_status <= 8'h00;
      rsp_fail <= 1'b0;
      rsp_reject <= 1'b0;
      rsp_mismatch <= 1'b0;
      erase_active <= 1'b0;
      erase_suspended <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      win_restart <= 1'b0;
      if (cyc.ack) begin
        req <= 1'b0;
      end
      case (st)
        HS_INIT: begin
          issue(1'b1, {{ADDR_W{1'b0}}, CMD_RESET});
          st <= HS_RESET;
        end
        HS_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op <= cmd_op;
            op_addr <= cmd_addr;
            op_data <= cmd_data;
            step <= 3'h0;
            have_prev <= 1'b0;
            to_cnt <= 2'h0;
            rsp_fail <= 1'b0;
            rsp_reject <= 1'b0;
            rsp_mismatch <= 1'b0;
            st <= HS_RESP;
            case (cmd_op)
              OP_READ: begin
                issue(1'b0, {cmd_addr, 8'h00});
                st <= HS_FINAL;
              end
              OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
                if (erase_active && (cmd_op != OP_PROGRAM || !erase_suspended)) begin
                  rsp_reject <= 1'b1;
                end else begin
                  issue(1'b1, seq_word(cmd_op, 3'h0, cmd_addr, cmd_data));
                  st <= HS_SEQ;
                end
              end
              OP_ADD_SECTOR: begin
                if (!erase_active || chip_mode || erase_suspended || win_cnt == 11'h000) begin
                  rsp_reject <= 1'b1;
                end else begin
                  issue(1'b0, {cmd_addr, 8'h00});
                  st <= HS_PRE;
                end
              end
              OP_WAIT: begin
                if (erase_suspended) begin
                  rsp_reject <= 1'b1;
                end else if (erase_active) begin
                  issue(1'b0, {cmd_addr, 8'h00});
                  st <= HS_POLL;
                end
              end
              OP_SUSPEND: begin
                if (!erase_active || chip_mode || erase_suspended) begin
                  rsp_reject <= 1'b1;
                end else begin
                  issue(1'b1, seq_word(cmd_op, 3'h0, cmd_addr, cmd_data));
                  st <= HS_SEQ;
                end
              end
              OP_RESUME: begin
                if (!erase_suspended) begin
                  rsp_reject <= 1'b1;
                end else begin
                  issue(1'b1, seq_word(cmd_op, 3'h0, cmd_addr, cmd_data));
                  st <= HS_SEQ;
                end
              end
              OP_RESET: begin
                issue(1'b1, seq_word(cmd_op, 3'h0, cmd_addr, cmd_data));
                st <= HS_SEQ;
              end
              default: rsp_reject <= 1'b1;
            endcase
          end
        end
        HS_SEQ: begin
          if (cyc.ack) begin
            if (seq_last(op, step)) begin
              st <= HS_RESP;
              case (op)
                OP_PROGRAM, OP_SUSPEND: begin
                  issue(1'b0, {op_addr, 8'h00});
                  st <= HS_POLL;
                end
                OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
                  erase_active <= 1'b1;
                  chip_mode <= (op == OP_CHIP_ERASE);
                  win_restart <= 1'b1;
                end
                OP_ADD_SECTOR: begin
                  win_restart <= 1'b1;
                  issue(1'b0, {op_addr, 8'h00});
                  st <= HS_POST;
                end
                OP_RESUME: erase_suspended <= 1'b0;
                default: begin
                  erase_active <= 1'b0;
                  erase_suspended <= 1'b0;
                end
              endcase
            end else begin
              step <= step + 3'h1;
              issue(1'b1, seq_word(op, step + 3'h1, op_addr, op_data));
            end
          end
        end
        HS_PRE, HS_POST: begin
          if (cyc.ack) begin
            rsp_status <= rd;
            st <= HS_RESP;
            if (rd[WINDOW_BIT]) begin
              rsp_reject <= 1'b1;
            end else if (st == HS_PRE) begin
              issue(1'b1, seq_word(op, 3'h0, op_addr, op_data));
              st <= HS_SEQ;
            end
          end
        end
        HS_POLL: begin
          if (cyc.ack) begin
            rsp_status <= rd;
            if (toggle_same) begin
              if (op == OP_SUSPEND) begin
                erase_suspended <= 1'b1;
                st <= HS_RESP;
              end else begin
                issue(1'b0, {op_addr, 8'h00});
                st <= HS_FINAL;
              end
            end else if (to_cnt == 2'h2 || susp_cnt == SUSPEND_CYC) begin
              rsp_fail <= 1'b1;
              issue(1'b1, {{ADDR_W{1'b0}}, CMD_RESET});
              st <= HS_RESET;
            end else begin
              prev <= rd;
              have_prev <= 1'b1;
              if (to_cnt != 2'h0 || rd[TIMEOUT_BIT]) begin
                to_cnt <= to_cnt + 2'h1;
              end
              issue(1'b0, {op_addr, 8'h00});
            end
          end
        end
        HS_FINAL: begin
          if (cyc.ack) begin
            rsp_data <= rd;
            st <= HS_RESP;
            if (op == OP_PROGRAM) begin
              rsp_mismatch <= (rd != op_data);
            end else if (op == OP_WAIT) begin
              rsp_mismatch <= !rd[POLL_BIT];
              erase_active <= 1'b0;
              chip_mode <= 1'b0;
            end
          end
        end
        HS_RESET: begin
          if (cyc.ack) begin
            erase_active <= 1'b0;
            erase_suspended <= 1'b0;
            chip_mode <= 1'b0;
            booted <= 1'b1;
            cmd_ready <= !booted;
            st <= booted ? HS_RESP : HS_IDLE;
          end
        end
        HS_RESP: begin
          rsp_valid <= 1'b1;
          cmd_ready <= 1'b1;
          st <= HS_IDLE;
        end
        default: st <= HS_IDLE;
      endcase
    end
  end

endmodule

// file: fsh_host_properties.sv
// Pin and user port checker for the flash host controller.
module fsh_host_properties (
  input logic sys_clk,
  input logic rstn,
  input logic cmd_valid,
  input logic cmd_ready,
  input logic rsp_valid,
  input logic erase_active,
  input logic erase_suspended,
  input logic [19:0] fl_addr,
  input logic [7:0] fl_dq_out,
  input logic fl_dq_oe,
  input logic fl_ce_n,
  input logic fl_oe_n,
  input logic fl_we_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Assertions
  chk_ready_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("cmd_ready stayed high after a take");
  chk_rsp_pulse: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid)
    else $error("response pulse too long or not ready with it");
  chk_write_pins: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe)
    else $error("write strobe without select or with output enable");
  chk_read_float: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n)
    else $error("host drives data during a read");
  chk_we_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*2] ##1 fl_we_n)
    else $error("write strobe not two cycles low");
  chk_word_hold: assert property (!fl_we_n |=> $stable(fl_addr) && $stable(fl_dq_out))
    else $error("address or data moved under the write strobe");
  chk_idle_quiet: assert property (cmd_ready |-> fl_ce_n && fl_oe_n && fl_we_n)
    else $error("bus active while idle");
  chk_susp_erase: assert property (erase_suspended |-> erase_active)
    else $error("suspended without an erase");
  cover property (rsp_valid && erase_suspended);
  cover property ($fell(fl_we_n));
  cover property (!fl_oe_n && erase_active);
endmodule

bind fsh_host fsh_host_properties u_props (.sys_clk(sys_clk), .rstn(rstn),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
  .erase_active(erase_active), .erase_suspended(erase_suspended), .fl_addr(fl_addr),
  .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
  .fl_we_n(fl_we_n));

// file: fsh_flash_model.sv
// Behavioural flash device answering strobed reads and writes.
module fsh_flash_model (
  input logic ce_n,
  input logic oe_n,
  input logic we_n,
  input logic [19:0] addr,
  input logic [7:0] din,
  output logic [7:0] dq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  logic [7:0] pdat = 8'hFF;
  logic [7:0] last = 8'hFF;
  logic [15:0] secs;
  logic [19:0] pa;
  int pleft, eleft, sleft;
  bit arm, prog, lock, prot, ers, chip, susp, tog, tog2, win, hit;
  realtime t_sec;
  function automatic logic [7:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // Released bus shows the inverse so a stale value is never mistaken for data.
  assign dq = (!ce_n && !oe_n) ? last : ~last;
  // ==========================================================================
  // Command writes
  always @(posedge we_n) if (!ce_n) begin
    win = chip || ($realtime - t_sec >= 80us);
    if (arm) begin
      arm = 0;
      prog = 1;
      pa = addr;
      pdat = din;
      prot = addr[19:16] == 4'hF;
      lock = (din & ~rd(addr)) != 8'h00;
      pleft = prot ? 2 : 4;
    end else if (din == 8'h07) begin
      prog = 0;
      ers = 0;
      susp = 0;
    end else if (din == 8'h03) arm = 1;
    else if (din == 8'h05 && !ers) begin
      ers = 1;
      chip = 1;
      secs = 16'hFFFF;
      eleft = 6;
    end else if (din == 8'h06 && ers && !susp) sleft = 2;
    else if (din == 8'h30 && susp) susp = 0;
    else if (din == 8'h30 && (!ers || !win)) begin
      if (!ers) secs = 16'h0000;
      ers = 1;
      chip = 0;
      eleft = 6;
      secs[addr[11:8]] = 1'b1;
      t_sec = $realtime;
    end
  end
  // ==========================================================================
  // Reads
  always @(negedge oe_n) begin
    #1;
    win = chip || ($realtime - t_sec >= 80us);
    hit = secs[addr[11:8]];
    if (ce_n) begin
    end else if (prog) begin
      last = {~pdat[7], tog, lock && pleft <= 0, 5'h00};
      tog = !tog;
      pleft--;
      if (pleft == 0 && !lock) begin
        prog = 0;
        if (!prot) mem[pa] = rd(pa) & pdat;
      end
    end else if (ers && susp && hit) begin
      last = {3'h6, 2'h0, tog2, 2'h0};
      tog2 = !tog2;
    end else if (ers && !susp) begin
      last = {1'b0, tog, 1'b0, win, tog2 && hit, 3'h0};
      tog = !tog;
      if (hit) tog2 = !tog2;
      if (sleft > 0) begin
        sleft--;
        if (sleft == 0) susp = 1;
      end else if (win) begin
        eleft = eleft - 1;
        if (eleft == 0) begin
          ers = 0;
          foreach (mem[k]) if (secs[k[11:8]] && k[19:16] != 4'hF) mem[k] = 8'hFF;
        end
      end
    end else last = rd(addr);
  end
endmodule

// file: fsh_host_tb.sv
// Self-checking testbench for the flash host controller.
module fsh_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fsh_pkg::*;
  logic sys_clk, rstn, cmd_valid, cmd_ready, rsp_valid, rsp_fail, rsp_reject, rsp_mismatch;
  logic erase_active, erase_suspended, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
  fsh_op_t cmd_op;
  logic [ADDR_W-1:0] cmd_addr, fl_addr;
  logic [DATA_W-1:0] cmd_data, rsp_data, rsp_status, fl_dq_out, fl_dq_in, dev_dq;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  assign fl_dq_in = fl_dq_oe ? fl_dq_out : dev_dq;
  fsh_host dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_status(rsp_status),
    .rsp_fail(rsp_fail), .rsp_reject(rsp_reject), .rsp_mismatch(rsp_mismatch),
    .erase_active(erase_active), .erase_suspended(erase_suspended), .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
  fsh_flash_model dev (.ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .addr(fl_addr),
    .din(fl_dq_out), .dq(dev_dq));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits are bounded so a device that never stops toggling cannot hang the run.
  task automatic run(input fsh_op_t op, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 8000) begin
      @(negedge sys_clk);
      n++;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 8000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 8000) check("response", 8'h00, 8'h01);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_program;
    run(OP_READ, 20'h00010, 8'h00);
    check("power-up read", rsp_data, 8'hFF);
    run(OP_PROGRAM, 20'h00100, 8'h5A);
    check("program data", rsp_data, 8'h5A);
    check("program mismatch", rsp_mismatch, 8'h00);
    run(OP_PROGRAM, 20'h00100, 8'hFF);
    check("lock fail", rsp_fail, 8'h01);
    run(OP_READ, 20'h00100, 8'h00);
    check("lock keeps data", rsp_data, 8'h5A);
    run(OP_PROGRAM, 20'hF0000, 8'h00);
    check("protected data", rsp_data, 8'hFF);
  endtask
  task automatic t_erase;
    run(OP_SECTOR_ERASE, 20'h00200, 8'h00);
    check("erase active", erase_active, 8'h01);
    run(OP_ADD_SECTOR, 20'h00100, 8'h00);
    check("add in window", rsp_reject, 8'h00);
    check("window status", rsp_status & 8'h88, 8'h00);
    run(OP_CHIP_ERASE, 20'h00000, 8'h00);
    check("busy refused", rsp_reject, 8'h01);
    run(OP_WAIT, 20'h00200, 8'h00);
    check("erase done", rsp_data, 8'hFF);
    run(OP_READ, 20'h00100, 8'h00);
    check("added sector erased", rsp_data, 8'hFF);
  endtask
  task automatic t_suspend;
    run(OP_SECTOR_ERASE, 20'h00300, 8'h00);
    run(OP_SUSPEND, 20'h00300, 8'h00);
    check("suspended", erase_suspended, 8'h01);
    check("suspend ok", rsp_fail, 8'h00);
    run(OP_RESUME, 20'h00300, 8'h00);
    check("resumed", erase_suspended, 8'h00);
    run(OP_RESUME, 20'h00300, 8'h00);
    check("second resume", rsp_reject, 8'h01);
    run(OP_SUSPEND, 20'h00300, 8'h00);
    check("suspend again", erase_suspended, 8'h01);
    run(OP_RESUME, 20'h00300, 8'h00);
    run(OP_WAIT, 20'h00300, 8'h00);
    check("erase finished", erase_active, 8'h00);
  endtask
  task automatic t_chip;
    run(OP_PROGRAM, 20'h00500, 8'h00);
    run(OP_CHIP_ERASE, 20'h00000, 8'h00);
    run(OP_WAIT, 20'h00700, 8'h00);
    run(OP_READ, 20'h00500, 8'h00);
    check("chip erased", rsp_data, 8'hFF);
  endtask
  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = 20'h00000;
    cmd_data = 8'h00;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    t_program;
    t_erase;
    t_suspend;
    t_chip;
    test_done;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      test_done;
    end
  end
endmodule
